/* ufc_pkg.sv */
// constants for the serial frame control and status block
// assumes a 32-bit apb master and a single 20 mhz clock
package ufc_pkg;
	localparam int AW = 8;
	// register byte offsets
	localparam logic [AW-1:0] OFF_MODE  = 8'h00;
	localparam logic [AW-1:0] OFF_ERR   = 8'h04;
	localparam logic [AW-1:0] OFF_TXST  = 8'h08;
	localparam logic [AW-1:0] OFF_TXBUF = 8'h0c;
	localparam logic [AW-1:0] OFF_RXBUF = 8'h10;
	localparam logic [AW-1:0] OFF_BAUD  = 8'h14;
	// mode register fields
	localparam int BIT_POWER = 7;
	localparam int BIT_TXE   = 6;
	localparam int BIT_RXE   = 5;
	localparam int BIT_PSH   = 4;
	localparam int BIT_PSL   = 3;
	localparam int BIT_CL    = 2;
	localparam int BIT_SL    = 1;
	localparam int BIT_ISRM  = 0;
	// error and transmit status fields
	localparam int BIT_PE  = 2;
	localparam int BIT_FE  = 1;
	localparam int BIT_OVE = 0;
	localparam int BIT_TBF = 1;
	localparam int BIT_TSF = 0;
	// reset values
	localparam logic [7:0] MODE_RST = 8'h01;
	localparam logic [7:0] BAUD_RST = 8'hff;
	localparam logic [7:0] BUF_RST  = 8'hff;
	// base clock is clk divided by this count
	localparam logic [3:0] BASE_DIV = 4'h2;
	// last data bit index for 7 and 8 bit characters
	localparam logic [2:0] LAST7 = 3'h6;
	localparam logic [2:0] LAST8 = 3'h7;
	typedef enum logic [2:0] {
		UFC_IDLE,
		UFC_START,
		UFC_DATA,
		UFC_PAR,
		UFC_STOP,
		UFC_STOP2
	} ufc_state_t;
endpackage

/* ufc_top.sv */
// serial frame control and status block with apb register access
// assumes apb master in the clk domain; serial input synchronous to clk
//
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ufc_top (
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   arst_n,
	// apb slave
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [ufc_pkg::AW-1:0] paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	// serial pins
	input  wire logic                   serial_input_pin,
	output logic                        serial_output_pin,
	// completion events
	output logic                        receive_done_irq,
	output logic                        receive_error_irq,
	output logic                        transmit_done_irq
);
	import ufc_pkg::*;

	logic [7:0] mode_q;
	logic [7:0] baud_q;
	logic [3:0] base_cnt_q;
	logic       base_tick_q;
	logic       power_run_q;
	logic       tx_run_q;
	logic       rx_run_q;
	ufc_state_t tx_state_q;
	ufc_state_t rx_state_q;
	logic [8:0] tx_tmr_q;
	logic [8:0] rx_tmr_q;
	logic [2:0] tx_cnt_q;
	logic [2:0] rx_cnt_q;
	logic [7:0] tx_buf_q;
	logic [7:0] tx_sh_q;
	logic       tx_par_q;
	logic       tx_full_q;
	logic       tx_busy_q;
	logic [7:0] rx_sh_q;
	logic       rx_par_q;
	logic [7:0] rx_buf_q;
	logic       rx_full_q;
	logic [2:0] err_q;
	logic       setup;
	logic       access;
	logic       wr;
	logic       rd;
	logic       mapped;
	logic [7:0] rd_mux;
	logic [7:0] tx_status;
	logic       par_on;
	logic       odd_sel;
	logic [2:0] last_bit;
	logic [8:0] bit_last;
	logic [8:0] bit_mid;
	logic       tx_wr;
	logic       tx_end;
	logic       rx_fin;
	logic [7:0] rx_data;
	logic       pe_set;
	logic       fe_set;
	logic       ove_set;
	logic       tx_par_d;

	assign setup    = psel && !penable;
	assign access   = psel && penable && pready;
	assign wr       = access && pwrite;
	assign rd       = access && !pwrite;
	assign par_on   = mode_q[BIT_PSH];
	assign odd_sel  = !mode_q[BIT_PSL];
	assign last_bit = mode_q[BIT_CL] ? LAST8 : LAST7;
	assign bit_last = {baud_q, 1'b0} - 9'h001;
	assign bit_mid  = {1'b0, baud_q};

	// base clock enable from clk
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			base_cnt_q  <= 4'h0;
			base_tick_q <= 1'b0;
		end else if (base_cnt_q == BASE_DIV - 4'h1) begin
			base_cnt_q  <= 4'h0;
			base_tick_q <= 1'b1;
		end else begin
			base_cnt_q  <= base_cnt_q + 4'h1;
			base_tick_q <= 1'b0;
		end
	end

	// power on and enables taken on the base clock, power off clears them at once
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			power_run_q <= 1'b0;
			tx_run_q    <= 1'b0;
			rx_run_q    <= 1'b0;
		end else if (!mode_q[BIT_POWER]) begin
			power_run_q <= 1'b0;
			tx_run_q    <= 1'b0;
			rx_run_q    <= 1'b0;
		end else if (base_tick_q) begin
			power_run_q <= 1'b1;
			tx_run_q    <= power_run_q && mode_q[BIT_TXE];
			rx_run_q    <= power_run_q && mode_q[BIT_RXE];
		end
	end

	// register read decode
	always_comb begin
		tx_status = 8'h00;
		if (mode_q[BIT_POWER] && mode_q[BIT_TXE]) begin
			tx_status[BIT_TBF] = tx_full_q;
			tx_status[BIT_TSF] = tx_busy_q;
		end
		mapped = 1'b1;
		rd_mux = 8'h00;
		case (paddr)
			OFF_MODE:  rd_mux = mode_q;
			OFF_ERR:   rd_mux = {5'h00, err_q};
			OFF_TXST:  rd_mux = tx_status;
			OFF_TXBUF: rd_mux = tx_buf_q;
			OFF_RXBUF: rd_mux = rx_buf_q;
			OFF_BAUD:  rd_mux = baud_q;
			default:   mapped = 1'b0;
		endcase
	end

	// apb answer: one cycle access phase
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= setup;
			pslverr <= setup && !mapped;
			if (setup) begin
				prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_mux};
			end
		end
	end

	// writable registers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_q <= MODE_RST;
			baud_q <= BAUD_RST;
		end else if (wr && paddr == OFF_MODE) begin
			mode_q <= pwdata[7:0];
		end else if (wr && paddr == OFF_BAUD) begin
			baud_q <= pwdata[7:0];
		end
	end

	assign tx_wr  = wr && paddr == OFF_TXBUF && tx_run_q;
	assign tx_end = base_tick_q && tx_tmr_q == bit_last &&
		(tx_state_q == UFC_STOP2 || (tx_state_q == UFC_STOP && !mode_q[BIT_SL]));

	// parity bit for the buffered character
	always_comb begin
		tx_par_d = 1'b0;
		if (par_on) begin
			tx_par_d = odd_sel ^ (^(tx_buf_q & {mode_q[BIT_CL], 7'h7f}));
		end
	end

	// transmitter
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_state_q        <= UFC_IDLE;
			tx_tmr_q          <= 9'h000;
			tx_cnt_q          <= 3'h0;
			tx_buf_q          <= BUF_RST;
			tx_sh_q           <= 8'h00;
			tx_par_q          <= 1'b0;
			tx_full_q         <= 1'b0;
			tx_busy_q         <= 1'b0;
			serial_output_pin <= 1'b1;
			transmit_done_irq <= 1'b0;
		end else if (!tx_run_q) begin
			tx_state_q        <= UFC_IDLE;
			tx_tmr_q          <= 9'h000;
			tx_cnt_q          <= 3'h0;
			tx_full_q         <= 1'b0;
			tx_busy_q         <= 1'b0;
			serial_output_pin <= 1'b1;
			transmit_done_irq <= 1'b0;
		end else begin
			transmit_done_irq <= tx_end;
			// first load waits for a base tick so the start bit is a full bit
			if ((tx_state_q == UFC_IDLE && tx_full_q && base_tick_q) ||
				(tx_end && tx_full_q)) begin
				tx_state_q        <= UFC_START;
				tx_sh_q           <= tx_buf_q;
				tx_par_q          <= tx_par_d;
				tx_full_q         <= 1'b0;
				tx_busy_q         <= 1'b1;
				tx_tmr_q          <= 9'h000;
				serial_output_pin <= 1'b0;
			end else if (tx_end) begin
				tx_state_q        <= UFC_IDLE;
				tx_busy_q         <= 1'b0;
				serial_output_pin <= 1'b1;
			end else if (base_tick_q && tx_state_q != UFC_IDLE) begin
				tx_tmr_q <= (tx_tmr_q == bit_last) ? 9'h000 : tx_tmr_q + 9'h001;
				if (tx_tmr_q == bit_last) begin
					case (tx_state_q)
						UFC_START: begin
							tx_state_q        <= UFC_DATA;
							tx_cnt_q          <= 3'h0;
							serial_output_pin <= tx_sh_q[0];
						end
						UFC_DATA: begin
							tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
							tx_cnt_q <= tx_cnt_q + 3'h1;
							if (tx_cnt_q == last_bit) begin
								tx_state_q        <= par_on || mode_q[BIT_PSL] ? UFC_PAR : UFC_STOP;
								serial_output_pin <= par_on ? tx_par_q : !mode_q[BIT_PSL];
							end else begin
								serial_output_pin <= tx_sh_q[1];
							end
						end
						UFC_PAR: begin
							tx_state_q        <= UFC_STOP;
							serial_output_pin <= 1'b1;
						end
						UFC_STOP: begin
							tx_state_q <= UFC_STOP2;
						end
						default: begin
							tx_state_q <= UFC_IDLE;
						end
					endcase
				end
			end
			if (tx_wr) begin
				tx_buf_q  <= pwdata[7:0];
				tx_full_q <= 1'b1;
			end
		end
	end

	assign rx_fin  = base_tick_q && rx_state_q == UFC_STOP && rx_tmr_q == bit_mid;
	assign rx_data = mode_q[BIT_CL] ? rx_sh_q : {1'b0, rx_sh_q[7:1]};
	assign pe_set  = rx_fin && par_on &&
		(rx_par_q != (odd_sel ^ (^rx_data)));
	assign fe_set  = rx_fin && !serial_input_pin;
	assign ove_set = rx_fin && rx_full_q;

	// receiver
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_state_q <= UFC_IDLE;
			rx_tmr_q   <= 9'h000;
			rx_cnt_q   <= 3'h0;
			rx_sh_q    <= 8'h00;
			rx_par_q   <= 1'b0;
		end else if (!rx_run_q) begin
			rx_state_q <= UFC_IDLE;
			rx_tmr_q   <= 9'h000;
			rx_cnt_q   <= 3'h0;
		end else if (base_tick_q) begin
			rx_tmr_q <= (rx_tmr_q == bit_last) ? 9'h000 : rx_tmr_q + 9'h001;
			case (rx_state_q)
				UFC_IDLE: begin
					rx_tmr_q <= 9'h000;
					if (!serial_input_pin) begin
						rx_state_q <= UFC_START;
					end
				end
				UFC_START: begin
					if (rx_tmr_q == bit_mid && serial_input_pin) begin
						rx_state_q <= UFC_IDLE;
					end else if (rx_tmr_q == bit_last) begin
						rx_state_q <= UFC_DATA;
						rx_cnt_q   <= 3'h0;
					end
				end
				UFC_DATA: begin
					if (rx_tmr_q == bit_mid) begin
						rx_sh_q <= {serial_input_pin, rx_sh_q[7:1]};
					end
					if (rx_tmr_q == bit_last) begin
						rx_cnt_q <= rx_cnt_q + 3'h1;
						if (rx_cnt_q == last_bit) begin
							rx_state_q <= par_on || mode_q[BIT_PSL] ? UFC_PAR : UFC_STOP;
						end
					end
				end
				UFC_PAR: begin
					if (rx_tmr_q == bit_mid) begin
						rx_par_q <= serial_input_pin;
					end
					if (rx_tmr_q == bit_last) begin
						rx_state_q <= UFC_STOP;
					end
				end
				default: begin
					if (rx_tmr_q == bit_mid) begin
						rx_state_q <= UFC_IDLE;
					end
				end
			endcase
		end
	end

	// receive buffer, error flags and receive events
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_buf_q          <= BUF_RST;
			rx_full_q         <= 1'b0;
			err_q             <= 3'h0;
			receive_done_irq  <= 1'b0;
			receive_error_irq <= 1'b0;
		end else if (!mode_q[BIT_POWER]) begin
			rx_buf_q          <= BUF_RST;
			rx_full_q         <= 1'b0;
			err_q             <= 3'h0;
			receive_done_irq  <= 1'b0;
			receive_error_irq <= 1'b0;
		end else begin
			if (rd && paddr == OFF_RXBUF) begin
				rx_full_q <= 1'b0;
			end
			if (rx_fin && !rx_full_q) begin
				rx_buf_q  <= rx_data;
				rx_full_q <= 1'b1;
			end
			// set wins over read clear
			err_q <= (err_q & {3{!(rd && paddr == OFF_ERR)}}) | {pe_set, fe_set, ove_set};
			receive_done_irq  <= rx_fin &&
				(!(pe_set || fe_set || ove_set) || mode_q[BIT_ISRM]);
			receive_error_irq <= rx_fin &&
				(pe_set || fe_set || ove_set) && !mode_q[BIT_ISRM];
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);

	property p_tx_reset;
		!tx_run_q |=> tx_state_q == UFC_IDLE && serial_output_pin && !tx_full_q;
	endproperty
	a_tx_reset: assert property (p_tx_reset) else $error("tx not reset");

	property p_rx_reset;
		!rx_run_q |=> rx_state_q == UFC_IDLE;
	endproperty
	a_rx_reset: assert property (p_rx_reset) else $error("rx not reset");

	property p_zero_par;
		rx_fin && !par_on |=> !$rose(err_q[BIT_PE]);
	endproperty
	a_zero_par: assert property (p_zero_par) else $error("parity flagged");

	property p_char_len;
		tx_state_q == UFC_DATA && !mode_q[BIT_CL] |-> tx_cnt_q <= LAST7;
	endproperty
	a_char_len: assert property (p_char_len) else $error("too many bits");

	property p_two_stop;
		tx_state_q == UFC_STOP2 |-> mode_q[BIT_SL] && serial_output_pin;
	endproperty
	a_two_stop: assert property (p_two_stop) else $error("bad stop");

	property p_route;
		rx_fin && fe_set && !mode_q[BIT_ISRM] && mode_q[BIT_POWER]
			|=> receive_error_irq && !receive_done_irq;
	endproperty
	a_route: assert property (p_route) else $error("bad routing");

	property p_overrun;
		rx_fin && rx_full_q && mode_q[BIT_POWER] |=> $stable(rx_buf_q) && err_q[BIT_OVE];
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun lost");

	property p_err_clear;
		rd && paddr == OFF_ERR && !rx_fin |=> err_q == 3'h0;
	endproperty
	a_err_clear: assert property (p_err_clear) else $error("flags kept");

	property p_txst_zero;
		!mode_q[BIT_POWER] && !mode_q[BIT_TXE] |-> tx_status == 8'h00;
	endproperty
	a_txst_zero: assert property (p_txst_zero) else $error("status not zero");

	property p_cont;
		tx_end && tx_full_q && tx_run_q |=> tx_state_q == UFC_START && !serial_output_pin;
	endproperty
	a_cont: assert property (p_cont) else $error("gap in stream");

	property p_buf_full;
		tx_wr |=> tx_full_q ##[1:2] tx_busy_q;
	endproperty
	a_buf_full: assert property (p_buf_full) else $error("buffer flag");
endmodule
`default_nettype wire

/* ufc_node.sv */
// remote serial node: drives the receive line, watches the transmit line
// assumes the clk domain of the block, bit time counted in clk cycles
`timescale 1ns/1ps
`default_nettype none
module ufc_node (
	// clock
	input  wire logic clk,
	// serial lines
	input  wire logic line_in,
	output logic      line_out
);
	int bit_clks = 32;
	int cyc      = 0;
	initial line_out = 1'b1; // idle high before any enable
	always @(negedge clk) cyc <= cyc + 1;
	task automatic put(input logic v);
		@(posedge clk);
		line_out <= v;
		repeat (bit_clks - 1) @(posedge clk);
	endtask
	// lsb first, one stop bit only, stop may be broken on purpose
	task automatic send(input logic [7:0] d, input int nd, input logic hp, input logic pb,
		input logic sb);
		put(1'b0);
		for (int i = 0; i < nd; i++) put(d[i]);
		if (hp) put(pb);
		put(sb);
		@(posedge clk);
		line_out <= 1'b1;
	endtask
	// t0 is the cycle of the start edge, -1 if none came
	task automatic recv(output logic [7:0] d, output logic p, output int t0, input int nd);
		int w;
		d = 8'h00;
		w = 0;
		@(negedge clk);
		while (line_in !== 1'b0 && w < 4000) begin
			@(negedge clk);
			w++;
		end
		t0 = (w < 4000) ? cyc : -1;
		repeat (bit_clks + bit_clks / 2) @(negedge clk);
		for (int i = 0; i < nd; i++) begin
			d[i] = line_in;
			repeat (bit_clks) @(negedge clk);
		end
		p = line_in;
		w = 0;
		while (line_in !== 1'b1 && w < 4000) begin
			@(negedge clk);
			w++;
		end
	endtask
endmodule
`default_nettype wire

/* tb.sv */
// self-checking bench for the serial frame control and status block
// assumes ufc_pkg, ufc_top and ufc_node; baud k set to 8, 32 clk a bit
`timescale 1ns/1ps
`default_nettype none
module tb;
	import ufc_pkg::*;
	logic          clk     = 1'b0;
	logic          arst_n  = 1'b0;
	logic          psel    = 1'b0;
	logic          penable = 1'b0;
	logic          pwrite  = 1'b0;
	logic [AW-1:0] paddr   = '0;
	logic [31:0]   pwdata  = '0;
	logic [31:0]   prdata, rd;
	logic          pready, pslverr, rx_line, tx_line, done_irq, err_irq, e, p1, p2;
	logic          tx_irq;
	int            n_tx = 0, tx0;
	logic [7:0]    a, b, d1, d2, m, mode;
	logic [1:0]    pm;
	int            errors = 0, num_checks = 0, n_done = 0, n_err = 0;
	int            seed = 32'hb8b357b5;
	int            t1, t2, nd, k0;
	always #25 clk = ~clk;
	always @(posedge clk) begin
		n_done <= n_done + done_irq;
		n_err  <= n_err + err_irq;
		n_tx   <= n_tx + tx_irq;
	end
	ufc_top i_dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .serial_input_pin(rx_line), .serial_output_pin(tx_line),
		.receive_done_irq(done_irq), .receive_error_irq(err_irq), .transmit_done_irq(tx_irq));
	ufc_node i_node (.clk(clk), .line_in(tx_line), .line_out(rx_line));
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [AW-1:0] ad, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge clk);
			n++;
		end
		if (n == 50) begin
			errors++;
			report_and_stop();
		end
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [AW-1:0] ad, input logic [7:0] v);
		apb(1'b1, ad, {24'h0, v});
	endtask
	task automatic rdc(input string what, input logic [AW-1:0] ad, input logic [7:0] exp);
		apb(1'b0, ad, 32'h0);
		chk(what, {24'h0, exp}, rd);
	endtask
	function automatic logic par(input logic [7:0] d, input logic [1:0] md);
		case (md)
			2'b10: return ~^d;
			2'b11: return ^d;
			default: return 1'b0;
		endcase
	endfunction
	// one received frame, then irq counts, flags and buffer
	task automatic rx_case(input logic [7:0] d, input logic bp, input logic bs,
		input logic [7:0] ef, input logic [7:0] eb, input logic rb);
		int c0, c1;
		logic x;
		c0 = n_done;
		c1 = n_err;
		i_node.send(d, nd, pm != 2'b00, par(d & m, pm) ^ bp, ~bs);
		repeat (4) @(posedge clk);
		x = (|ef) & ~mode[BIT_ISRM];
		chk("done irq", x ? 0 : 1, n_done - c0);
		chk("error irq", x ? 1 : 0, n_err - c1);
		rdc("error status", OFF_ERR, ef);
		if (rb) rdc("receive buffer", OFF_RXBUF, eb);
	endtask
	initial begin
		repeat (100000) @(posedge clk);
		errors++;
		report_and_stop();
	end
	initial begin
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		rdc("mode reset", OFF_MODE, MODE_RST);
		rdc("error reset", OFF_ERR, 8'h00);
		rdc("tx status reset", OFF_TXST, 8'h00);
		rdc("baud reset", OFF_BAUD, BAUD_RST);
		apb(1'b0, 8'h18, 32'h0);
		chk("unmapped slverr", 32'h1, {31'h0, e});
		wr(OFF_BAUD, 8'h08);
		for (int i = 0; i < 4; i++) begin
			pm = i[1:0];
			nd = i[1] ? 7 : 8;
			m = i[1] ? 8'h7f : 8'hff;
			mode = {3'b100, pm, ~i[1], i[0], i[0] ^ i[1]};
			wr(OFF_MODE, mode);
			repeat (8) @(posedge clk);
			mode[BIT_TXE] = 1'b1;
			mode[BIT_RXE] = 1'b1;
			wr(OFF_MODE, mode);
			repeat (8) @(posedge clk);
			a = $random(seed);
			b = $random(seed);
			tx0 = n_tx;
			fork
				begin
					i_node.recv(d1, p1, t1, nd);
					i_node.recv(d2, p2, t2, nd);
				end
				begin
					wr(OFF_TXBUF, a);
					k0 = 0;
					rd = 32'h2;
					while (rd[BIT_TBF] !== 1'b0 && k0 < 100) begin
						apb(1'b0, OFF_TXST, 32'h0);
						k0++;
					end
					wr(OFF_TXBUF, b);
				end
			join
			chk("tx data", a & m, d1);
			chk("tx data next", b & m, d2);
			if (pm != 2'b00) chk("tx parity", par(a & m, pm), p1);
			chk("frame spacing", (2 + nd + (pm != 2'b00) + i[0]) * 32, t2 - t1);
			rx_case(a, 1'b0, 1'b0, 8'h00, a & m, 1'b1);
			rx_case(a, 1'b1, 1'b0, {5'h0, pm[1], 2'b00}, a & m, 1'b1);
			rx_case(b, 1'b0, 1'b1, 8'h02, b & m, 1'b1);
			rx_case(a, 1'b0, 1'b0, 8'h00, 8'h00, 1'b0);
			rx_case(b, 1'b0, 1'b0, 8'h01, a & m, 1'b1);
			chk("tx done irq", 32'h2, n_tx - tx0);
		end
		i_node.send(a, nd, 1'b1, 1'b0, 1'b0);
		wr(OFF_TXBUF, b);
		repeat (100) @(posedge clk);
		wr(OFF_MODE, mode & 8'h9f);
		repeat (8) @(posedge clk);
		chk("line idle", 32'h1, {31'h0, tx_line});
		wr(OFF_MODE, 8'h00);
		rdc("tx status off", OFF_TXST, 8'h00);
		rdc("error off", OFF_ERR, 8'h00);
		rdc("rx buffer off", OFF_RXBUF, BUF_RST);
		report_and_stop();
	end
endmodule
`default_nettype wire
